// file: abwp_apb_slave.sv
// APB peripheral model: one word of storage shared by every slot.
// Assumes the master holds its request until PREADY is sampled.
`timescale 1ns/1ps
module abwp_apb_slave (
    // Clock
    input wire logic clk,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Control
    input wire logic [1:0] waits,
    input wire logic fail,
    output logic [31:0] mem
);
    // ==========================================
    // Wait counter; zero waits allowed
    logic [1:0] cnt_ff;
    assign pready = psel && penable && cnt_ff == waits;
    assign pslverr = pready && fail;
    // Not ready: inverted data so stale values never pass; reads carry strobed lanes only
    assign prdata = pready ? (mem & {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}}) : ~mem;
    always @(posedge clk) begin
        cnt_ff <= (!(psel && penable) || pready) ? 2'h0 : cnt_ff + 2'h1;
        for (int i = 0; i < 4; i++) begin
            if (pready && pwrite && !fail && pstrb[i]) mem[i*8+:8] <= pwdata[i*8+:8];
        end
    end
endmodule

// file: abwp_bridge.sv
// AHB-to-APB bridge with per-peripheral write protection.
// Assumes bridge_bus_clock is CORE_CLK, already enabled before use.
`timescale 1ns/1ps
module abwp_bridge (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // AHB slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [3:0] HPROT,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [1:0] HRESP,
    output logic [31:0] HRDATA,
    // APB master
    output logic [31:0] PADDR,
    output logic PSEL,
    output logic PENABLE,
    output logic PWRITE,
    output logic [2:0] PPROT,
    output logic [3:0] PSTRB,
    output logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Protection status
    output logic [31:0] WP_STATE
);
    abwp_pkg::abwp_state_t state_ff, nxt_state;
    logic [31:0] addr_ff;
    logic write_ff;
    logic [3:0] strb_ff;
    logic [31:0] wp_ff, nxt_wp;
    logic hready_ff, nxt_hready;
    logic [1:0] hresp_ff, nxt_hresp;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic psel_ff, penable_ff, pwrite_ff;
    logic wr_wait_ff;
    logic [2:0] pprot_ff;
    logic [3:0] pstrb_ff;
    logic [31:0] paddr_ff, pwdata_ff;

    // ==========================================
    // Address phase decode
    wire start = HSEL && HREADY && (HTRANS == abwp_pkg::HTRANS_NONSEQ || HTRANS == abwp_pkg::HTRANS_SEQ);
    wire [3:0] lane_mask = (HSIZE == abwp_pkg::HSIZE_BYTE) ? (4'h1 << HADDR[1:0]) :
        (HSIZE == abwp_pkg::HSIZE_HALF) ? (HADDR[1] ? 4'hc : 4'h3) : 4'hf;
    wire [31:0] word_addr = {HADDR[31:2], 2'h0};
    wire is_clr = (word_addr == abwp_pkg::WP_CLEAR_OFFSET);
    wire is_set = (word_addr == abwp_pkg::WP_SET_OFFSET);
    wire in_local = HADDR < abwp_pkg::PERIPH_SPAN;
    wire [31:0] slot = (HADDR - abwp_pkg::PERIPH_SPAN) / abwp_pkg::PERIPH_SPAN;
    wire periph_hit = !in_local && (slot < 32'h20);
    wire periph_prot = periph_hit && wp_ff[slot[4:0]];
    wire acc_clr = write_ff && (addr_ff[31:2] == abwp_pkg::WP_CLEAR_OFFSET[31:2]);
    wire acc_set = write_ff && (addr_ff[31:2] == abwp_pkg::WP_SET_OFFSET[31:2]);
    // Byte-lane expansion of the strobes for the data phase
    logic [31:0] byte_mask;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign byte_mask[gi*8 +: 8] = {8{strb_ff[gi]}};
        end
    endgenerate
    wire [31:0] wdata_m = HWDATA & byte_mask;
    // Only implemented peripheral bits are protectable
    wire [31:0] impl = 32'h1 << abwp_pkg::PM_BIT | 32'h1 << abwp_pkg::SYSTEM_CONTROL_PROTECT_BIT_BIT |
        32'h1 << abwp_pkg::CLOCK_GENERATOR_PROTECT_BIT_BIT;
    wire [31:0] clr_hit = wdata_m & impl;
    wire dbl_unprot = acc_clr && |(clr_hit & ~wp_ff);
    wire dbl_prot = acc_set && |(clr_hit & wp_ff);

    // ==========================================
    // Next-state logic
    always_comb begin
        nxt_state = state_ff;
        nxt_wp = wp_ff;
        nxt_hready = hready_ff;
        nxt_hresp = hresp_ff;
        nxt_hrdata = hrdata_ff;
        case (state_ff)
            abwp_pkg::ABWP_IDLE: begin
                nxt_hready = 1'b1;
                nxt_hresp = abwp_pkg::HRESP_OKAY;
                if (start) begin
                    nxt_hready = 1'b0;
                    if (in_local) begin
                        nxt_state = abwp_pkg::ABWP_DONE;
                        nxt_hrdata = (is_clr || is_set) ? wp_ff : 32'h0;
                    end else if (HWRITE && periph_prot) begin
                        nxt_state = abwp_pkg::ABWP_ERR1;
                    end else begin
                        nxt_state = abwp_pkg::ABWP_APB;
                    end
                end
            end
            abwp_pkg::ABWP_DONE: begin
                // Data phase of local register read or write; HWDATA valid now for writes
                if (dbl_prot || dbl_unprot) begin
                    nxt_state = abwp_pkg::ABWP_ERR1;
                end else begin
                    if (acc_clr) nxt_wp = wp_ff & ~clr_hit;
                    if (acc_set) nxt_wp = wp_ff | clr_hit;
                    nxt_hready = 1'b1;
                    nxt_state = abwp_pkg::ABWP_IDLE;
                end
            end
            abwp_pkg::ABWP_APB: begin
                if (psel_ff && PREADY) begin
                    nxt_hrdata = PRDATA;
                    if (PSLVERR) begin
                        nxt_state = abwp_pkg::ABWP_ERR1;
                    end else begin
                        nxt_hready = 1'b1;
                        nxt_state = abwp_pkg::ABWP_IDLE;
                    end
                end
            end
            abwp_pkg::ABWP_ERR1: begin
                // Two-cycle AHB error response
                nxt_hresp = abwp_pkg::HRESP_ERROR;
                nxt_hready = 1'b0;
                nxt_state = abwp_pkg::ABWP_ERR2;
            end
            abwp_pkg::ABWP_ERR2: begin
                nxt_hready = 1'b1;
                nxt_state = abwp_pkg::ABWP_IDLE;
            end
            default: nxt_state = abwp_pkg::ABWP_IDLE;
        endcase
    end

    // ==========================================
    // Registers
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            state_ff <= abwp_pkg::ABWP_IDLE;
            wp_ff <= abwp_pkg::WP_RESET;
            hready_ff <= 1'b1;
            hresp_ff <= abwp_pkg::HRESP_OKAY;
            hrdata_ff <= 32'h0;
            addr_ff <= 32'h0;
            write_ff <= 1'b0;
            strb_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            wp_ff <= nxt_wp;
            hready_ff <= nxt_hready;
            hresp_ff <= nxt_hresp;
            hrdata_ff <= nxt_hrdata;
            if (start && state_ff == abwp_pkg::ABWP_IDLE) begin
                addr_ff <= HADDR;
                write_ff <= HWRITE;
                strb_ff <= lane_mask;
            end
        end
    end

    // Merged APB cycle; writes wait one cycle for HWDATA so data never lags PSEL
    wire apb_go = state_ff == abwp_pkg::ABWP_IDLE && nxt_state == abwp_pkg::ABWP_APB;
    wire apb_end = state_ff == abwp_pkg::ABWP_APB && psel_ff && PREADY;
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            psel_ff <= 1'b0;
            penable_ff <= 1'b0;
            pwrite_ff <= 1'b0;
            pprot_ff <= 3'h0;
            pstrb_ff <= 4'h0;
            paddr_ff <= 32'h0;
            pwdata_ff <= 32'h0;
            wr_wait_ff <= 1'b0;
        end else begin
            wr_wait_ff <= apb_go && HWRITE;
            if (apb_go) begin
                psel_ff <= !HWRITE;
                penable_ff <= !HWRITE;
                pwrite_ff <= HWRITE;
                paddr_ff <= HADDR;
                pprot_ff <= {~HPROT[0], 1'b0, HPROT[1]};
                pstrb_ff <= lane_mask;
            end else if (wr_wait_ff) begin
                psel_ff <= 1'b1;
                penable_ff <= 1'b1;
                pwdata_ff <= HWDATA;
            end else if (apb_end) begin
                psel_ff <= 1'b0;
                penable_ff <= 1'b0;
            end
        end
    end

    assign HREADYOUT = hready_ff;
    assign HRESP = hresp_ff;
    assign HRDATA = hrdata_ff;
    assign PSEL = psel_ff;
    assign PENABLE = penable_ff;
    assign PWRITE = pwrite_ff;
    assign PPROT = pprot_ff;
    assign PSTRB = pstrb_ff;
    assign PADDR = paddr_ff;
    assign PWDATA = pwdata_ff;
    assign WP_STATE = wp_ff;
endmodule

// file: abwp_bridge_props.sv
// Checker: handshake, error and protection timing at the bridge ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module abwp_bridge_props (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // AHB side
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic [1:0] HRESP,
    // APB side and status
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [3:0] PSTRB,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [31:0] WP_STATE
);
    // ==========================================
    // Properties
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    wire take = HSEL && HREADY && HTRANS[1];
    property p_take; take |=> !HREADYOUT; endproperty
    a_take: assert property (p_take) else $error("no wait after address");
    property p_bound; take |-> ##[2:12] HREADYOUT; endproperty
    a_bound: assert property (p_bound) else $error("transfer never ends");
    property p_merge; $rose(PSEL) |-> PENABLE && PSTRB != 4'h0; endproperty
    a_merge: assert property (p_merge) else $error("split cycle or no lanes");
    property p_hold; PSEL && !PREADY |=> PSEL && $stable(PSTRB); endproperty
    a_hold: assert property (p_hold) else $error("request dropped in wait");
    property p_ok; PSEL && PREADY && !PSLVERR |=> HREADYOUT && HRESP == 2'h0; endproperty
    a_ok: assert property (p_ok) else $error("bad okay completion");
    property p_slverr;
        PSEL && PREADY && PSLVERR |=> !HREADYOUT ##1 (!HREADYOUT && HRESP == 2'h1) ##1 (HREADYOUT && HRESP == 2'h1);
    endproperty
    a_slverr: assert property (p_slverr) else $error("slave error lost");
    property p_block;
        take && HWRITE && HADDR[31:13] == 19'h0 && WP_STATE[HADDR[12:10] - 3'h1] |=> !PSEL ##1 !PSEL && HRESP == 2'h1;
    endproperty
    a_block: assert property (p_block) else $error("protected write passed");
    property p_bits; WP_STATE[31:4] == 28'h0 && !WP_STATE[0]; endproperty
    a_bits: assert property (p_bits) else $error("stray protect bit");
    property p_err2; HRESP == 2'h1 && !HREADYOUT |=> HRESP == 2'h1 && HREADYOUT; endproperty
    a_err2: assert property (p_err2) else $error("error not two cycles");
    cover property (take && HWRITE);
    cover property (PSEL && PREADY && PSLVERR);
    cover property (HRESP == 2'h1 && HREADYOUT);
endmodule
bind abwp_bridge abwp_bridge_props u_props (.CORE_CLK, .NRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY,
    .HREADYOUT, .HRESP, .PSEL, .PENABLE, .PSTRB, .PREADY, .PSLVERR, .WP_STATE);

// file: abwp_pkg.sv
// Constants shared by the bridge and protection logic.
// Assumes a 32-bit AHB-Lite slave port and a 32-bit APB4 master port.
package abwp_pkg;
    // ==========================================
    // Register map (bridge-local window)
    localparam logic [31:0] WP_CLEAR_OFFSET = 32'h00000000;
    localparam logic [31:0] WP_SET_OFFSET = 32'h00000004;
    localparam logic [31:0] PERIPH_SPAN = 32'h00000400;
    localparam logic [31:0] WP_RESET = 32'h00000000;
    // ==========================================
    // Protection bit positions
    localparam int PM_BIT = 1;
    localparam int SYSTEM_CONTROL_PROTECT_BIT_BIT = 2;
    localparam int CLOCK_GENERATOR_PROTECT_BIT_BIT = 3;
    localparam int PERIPH_LO = 1;
    localparam int PERIPH_HI = 3;
    // ==========================================
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    localparam logic [1:0] HRESP_ERROR = 2'h1;
    // ==========================================
    // Bridge states
    typedef enum logic [2:0] {
        ABWP_IDLE = 3'b000,
        ABWP_APB = 3'b001,
        ABWP_ERR1 = 3'b010,
        ABWP_ERR2 = 3'b011,
        ABWP_DONE = 3'b100
    } abwp_state_t;
endpackage

// file: abwp_tb.sv
// Bench: AHB master tasks, APB model behind the bridge.
// Assumes the bridge clock is on from time zero.
`timescale 1ns/1ps
module tb;
    localparam logic [31:0] CLR = abwp_pkg::WP_CLEAR_OFFSET;
    localparam logic [31:0] SET = abwp_pkg::WP_SET_OFFSET;
    localparam logic [1:0] OK = abwp_pkg::HRESP_OKAY;
    localparam logic [1:0] ER = abwp_pkg::HRESP_ERROR;
    localparam logic [31:0] GB = 32'h1 << abwp_pkg::CLOCK_GENERATOR_PROTECT_BIT_BIT;
    localparam logic [31:0] SB = 32'h1 << abwp_pkg::SYSTEM_CONTROL_PROTECT_BIT_BIT;
    localparam logic [31:0] PB = 32'h1 << abwp_pkg::PM_BIT;
    logic CORE_CLK = 1'b0, NRST = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, fail = 1'b0;
    logic [1:0] HTRANS = 2'h0, waits = 2'h1;
    logic [2:0] HSIZE = 3'h2, PPROT;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, rd, HRDATA, PADDR, PWDATA, PRDATA, WP_STATE, mem;
    logic HREADYOUT, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [1:0] HRESP;
    logic [3:0] PSTRB, HPROT = 4'h3;
    int err_count = 0, total_checks = 0, cyc = 0;
    always #10 CORE_CLK = ~CORE_CLK;
    abwp_bridge dut (.CORE_CLK, .NRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HPROT, .HWDATA,
        .HREADY(HREADYOUT), .HREADYOUT, .HRESP, .HRDATA, .PADDR, .PSEL, .PENABLE, .PWRITE, .PPROT,
        .PSTRB, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .WP_STATE);
    abwp_apb_slave per (.clk(CORE_CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .pstrb(PSTRB),
        .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR), .waits, .fail, .mem);
    // ==========================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz,
        input logic [1:0] er);
        @(posedge CORE_CLK);
        HSEL <= 1'b1;
        HADDR <= a;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HSIZE <= sz;
        @(posedge CORE_CLK);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        chk({30'h0, HRESP}, {30'h0, er});
        rd = HRDATA;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs;
        xfer(0, CLR, 0, 2, OK);
        chk(rd, abwp_pkg::WP_RESET);
        xfer(1, SET, GB, 2, OK);
        xfer(0, CLR, 0, 2, OK);
        chk(rd, GB);
        xfer(1, SET, SB, 0, OK);
        xfer(1, SET, GB, 2, ER);
        xfer(0, SET, 0, 2, OK);
        chk(rd, GB | SB);
        xfer(1, CLR, GB, 1, OK);
        xfer(1, CLR, GB, 2, ER);
        xfer(1, CLR, 0, 2, OK);
        xfer(1, SET, PB, 1, OK);
        xfer(1, SET + 2, GB, 1, OK);
        xfer(0, SET, 0, 2, OK);
        chk(rd, SB | PB);
        chk(WP_STATE, SB | PB);
        $display("t_regs done, mismatches %0d", err_count);
    endtask
    task automatic t_prot;
        xfer(1, 32'h1000, 32'h11223344, 2, OK);
        xfer(1, 32'hc00, 0, 2, ER);
        xfer(0, 32'hc00, 0, 2, OK);
        chk(rd, 32'h11223344);
        $display("t_prot done, mismatches %0d", err_count);
    endtask
    task automatic t_apb;
        waits <= 2'h2;
        xfer(1, 32'h1002, 32'h00ab0000, 0, OK);
        chk(mem, 32'h11ab3344);
        xfer(0, 32'h1001, 0, 0, OK);
        chk(rd, 32'h00003300);
        fail <= 1'b1;
        xfer(1, 32'h1000, 0, 2, ER);
        chk(mem, 32'h11ab3344);
        fail <= 1'b0;
        waits <= 2'h0;
        HPROT <= 4'h2;
        xfer(1, 32'h1000, 32'h55667788, 2, OK);
        chk(mem, 32'h55667788);
        chk(PADDR, 32'h00001000);
        chk({27'h0, PWRITE, PSTRB}, 32'h0000001f);
        chk({29'h0, PPROT}, 32'h00000005);
        $display("t_apb done, mismatches %0d", err_count);
    endtask
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        repeat (3) @(posedge CORE_CLK);
        NRST <= 1'b1;
        t_regs();
        t_prot();
        t_apb();
        test_done();
    end
endmodule
